// ---- include/io_space_pkg.sv ----
package io_space_pkg;

	// ------------------------------------------------------------
	// Space geometry
	// ------------------------------------------------------------
	localparam int         IO_LOCS       = 64;
	localparam logic [7:0] IO_LAST       = 8'h3f;
	localparam logic [7:0] BIT_LAST      = 8'h1f;
	localparam logic [7:0] DATA_IO_BASE  = 8'h20;
	localparam logic [7:0] DATA_IO_LAST  = 8'h5f;
	localparam logic [7:0] DATA_EXT_BASE = 8'h60;
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam int         PIN_PORTS     = 7;
	localparam int         PIN_STRIDE    = 3;

	// ------------------------------------------------------------
	// Register offsets in the in/out space
	// ------------------------------------------------------------
	localparam logic [5:0] PINS_A_INPUT             = 6'h00;
	localparam logic [5:0] DIRECTION_A              = 6'h01;
	localparam logic [5:0] OUTPUT_LATCH_A           = 6'h02;
	localparam logic [5:0] PINS_B_INPUT             = 6'h03;
	localparam logic [5:0] DIRECTION_B              = 6'h04;
	localparam logic [5:0] OUTPUT_LATCH_B           = 6'h05;
	localparam logic [5:0] PINS_C_INPUT             = 6'h06;
	localparam logic [5:0] DIRECTION_C              = 6'h07;
	localparam logic [5:0] OUTPUT_LATCH_C           = 6'h08;
	localparam logic [5:0] PINS_D_INPUT             = 6'h09;
	localparam logic [5:0] DIRECTION_D              = 6'h0a;
	localparam logic [5:0] OUTPUT_LATCH_D           = 6'h0b;
	localparam logic [5:0] PINS_E_INPUT             = 6'h0c;
	localparam logic [5:0] DIRECTION_E              = 6'h0d;
	localparam logic [5:0] OUTPUT_LATCH_E           = 6'h0e;
	localparam logic [5:0] PINS_F_INPUT             = 6'h0f;
	localparam logic [5:0] DIRECTION_F              = 6'h10;
	localparam logic [5:0] OUTPUT_LATCH_F           = 6'h11;
	localparam logic [5:0] PINS_G_INPUT             = 6'h12;
	localparam logic [5:0] DIRECTION_G              = 6'h13;
	localparam logic [5:0] OUTPUT_LATCH_G           = 6'h14;
	localparam logic [5:0] TIMER0_FLAGS             = 6'h15;
	localparam logic [5:0] TIMER1_FLAGS             = 6'h16;
	localparam logic [5:0] TIMER2_FLAGS             = 6'h17;
	localparam logic [5:0] EXTERNAL_IRQ_FLAGS       = 6'h1c;
	localparam logic [5:0] EXTERNAL_IRQ_MASK        = 6'h1d;
	localparam logic [5:0] SCRATCH_0                = 6'h1e;
	localparam logic [5:0] NONVOLATILE_CONTROL      = 6'h1f;
	localparam logic [5:0] NONVOLATILE_DATA         = 6'h20;
	localparam logic [5:0] NONVOLATILE_ADDRESS_LOW  = 6'h21;
	localparam logic [5:0] NONVOLATILE_ADDRESS_HIGH = 6'h22;
	localparam logic [5:0] PRESCALER_SYNC_CONTROL   = 6'h23;
	localparam logic [5:0] TIMER0_CONTROL           = 6'h24;
	localparam logic [5:0] TIMER0_COUNT             = 6'h26;
	localparam logic [5:0] TIMER0_COMPARE_VALUE     = 6'h27;
	localparam logic [5:0] SCRATCH_1                = 6'h2a;
	localparam logic [5:0] SCRATCH_2                = 6'h2b;
	localparam logic [5:0] SERIAL_PORT_CONTROL      = 6'h2c;
	localparam logic [5:0] SERIAL_PORT_FLAGS        = 6'h2d;
	localparam logic [5:0] SERIAL_SHIFT_DATA        = 6'h2e;
	localparam logic [5:0] COMPARATOR_CONTROL_FLAGS = 6'h30;
	localparam logic [5:0] DEBUG_DATA_CHANNEL       = 6'h31;
	localparam logic [5:0] SLEEP_CONTROL            = 6'h33;
	localparam logic [5:0] RESET_CAUSE_FLAGS        = 6'h34;
	localparam logic [5:0] CORE_CONTROL             = 6'h35;
	localparam logic [5:0] SELF_PROGRAM_CONTROL     = 6'h37;

	// ------------------------------------------------------------
	// Core operations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		IO_IN_INSTR             = 3'h0,
		IO_OUT_INSTR            = 3'h1,
		SET_SINGLE_BIT_INSTR    = 3'h3,
		CLEAR_SINGLE_BIT_INSTR  = 3'h2,
		SKIP_IF_BIT_SET_INSTR   = 3'h6,
		SKIP_IF_BIT_CLEAR_INSTR = 3'h7,
		DATA_LOAD_INSTR         = 3'h5,
		DATA_STORE_INSTR        = 3'h4
	} op_t;

endpackage // io_space_pkg

// ---- include/write_bus_if.sv ----
interface write_bus_if;

	logic       wr_en;
	logic [5:0] loc;
	logic [7:0] data;
	logic [7:0] mask;

	modport source (output wr_en, output loc, output data, output mask);
	modport sink   (input wr_en, input loc, input data, input mask);

endinterface // write_bus_if

// ---- hw/pin_sync.sv ----
module pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	// Level crossing
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule // pin_sync

// ---- hw/reg_cell.sv ----
module reg_cell
	import io_space_pkg::*;
#(
	parameter logic [5:0] LOC = 6'h00,
	parameter logic [7:0] RW  = 8'h00,
	parameter logic [7:0] W1C = 8'h00,
	parameter logic [7:0] SET = 8'h00,
	parameter logic [7:0] RO  = 8'h00
) (
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// Write broadcast
	write_bus_if.sink       wb,
	// Hardware side
	input  wire logic [7:0] i_set,
	input  wire logic [7:0] i_live,
	output logic      [7:0] o_stored,
	output logic      [7:0] o_read
);

	logic [7:0] value_r;

	// Single-bit operations arrive with a one-hot lane
	wire logic [7:0] lane = (wb.wr_en && wb.loc == LOC) ? wb.mask : 8'h00;
	wire logic [7:0] kept = (value_r & ~(lane & RW)) | (wb.data & lane & RW);
	wire logic [7:0] clr  = wb.data & lane & W1C;
	// Set wins so that an event in the clearing cycle survives
	wire logic [7:0] value_nxt = ((kept & ~clr) | (i_set & SET)) & (RW | W1C);

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			value_r <= REG_RESET;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign o_stored = value_r;
	assign o_read   = value_r | (i_live & RO);

endmodule // reg_cell

// ---- hw/io_space_register_decoder.sv ----
// Notes on behaviour
// - Single-bit set and clear act only on addresses 0x00 to 0x1F.
// - Bit tests on addresses 0x00 to 0x1F read one bit for skipping.
// - Writing one clears a status flag; writing zero leaves it. Reset cause flags are the exception and are written like ordinary bits.
// - Single-bit operations change only the addressed bit, never other flags.
// - In/out operations address 0x00 to 0x3F, a 64 location field.
// - Data-space accesses see the registers at their address plus 0x20.
// - Data addresses 0x60 to 0xFF are reached by data loads and stores only.
module io_space_register_decoder
	import io_space_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_rst,
	// Core access
	input  wire logic                  i_req,
	input  wire op_t                   i_op,
	input  wire logic [7:0]            i_addr,
	input  wire logic [7:0]            i_wdata,
	input  wire logic [2:0]            i_bit_sel,
	output logic                       o_ack,
	output logic      [7:0]            o_rdata,
	output logic                       o_skip,
	output logic                       o_refused,
	// Port pins
	input  wire logic [PIN_PORTS-1:0][7:0] i_port_pins,
	// Peripheral side
	input  wire logic [IO_LOCS-1:0][7:0] i_live_status,
	input  wire logic [IO_LOCS-1:0][7:0] i_flag_set,
	output logic      [IO_LOCS-1:0][7:0] o_io_image,
	output logic      [IO_LOCS-1:0]      o_io_written,
	// Extended data space
	output logic                       o_ext_req,
	output logic                       o_ext_write,
	output logic      [7:0]            o_ext_addr,
	output logic      [7:0]            o_ext_wdata,
	input  wire logic [7:0]            i_ext_rdata
);

	// ------------------------------------------------------------
	// Bit layout of each location
	// ------------------------------------------------------------
	function automatic logic [7:0] rw_mask(input logic [5:0] a);
		case (a)
			DIRECTION_A, OUTPUT_LATCH_A,
			DIRECTION_B, OUTPUT_LATCH_B,
			DIRECTION_C, OUTPUT_LATCH_C,
			DIRECTION_D, OUTPUT_LATCH_D,
			DIRECTION_E, OUTPUT_LATCH_E,
			DIRECTION_F, OUTPUT_LATCH_F,
			SCRATCH_0, SCRATCH_1, SCRATCH_2,
			NONVOLATILE_DATA, NONVOLATILE_ADDRESS_LOW,
			TIMER0_CONTROL, TIMER0_COUNT, TIMER0_COMPARE_VALUE,
			SERIAL_PORT_CONTROL, SERIAL_SHIFT_DATA,
			DEBUG_DATA_CHANNEL: begin
				rw_mask = 8'hff;
			end
			DIRECTION_G, OUTPUT_LATCH_G: begin
				rw_mask = 8'h1f;
			end
			EXTERNAL_IRQ_MASK: begin
				rw_mask = 8'hf1;
			end
			NONVOLATILE_CONTROL, SLEEP_CONTROL: begin
				rw_mask = 8'h0f;
			end
			NONVOLATILE_ADDRESS_HIGH: begin
				rw_mask = 8'h07;
			end
			PRESCALER_SYNC_CONTROL: begin
				rw_mask = 8'h83;
			end
			SERIAL_PORT_FLAGS: begin
				rw_mask = 8'h01;
			end
			COMPARATOR_CONTROL_FLAGS: begin
				rw_mask = 8'hcf;
			end
			RESET_CAUSE_FLAGS: begin
				rw_mask = 8'h1f;
			end
			CORE_CONTROL: begin
				rw_mask = 8'h93;
			end
			SELF_PROGRAM_CONTROL: begin
				rw_mask = 8'h9f;
			end
			default: begin
				rw_mask = 8'h00;
			end
		endcase
	endfunction

	function automatic logic [7:0] w1c_mask(input logic [5:0] a);
		case (a)
			TIMER0_FLAGS, TIMER2_FLAGS: begin
				w1c_mask = 8'h03;
			end
			TIMER1_FLAGS: begin
				w1c_mask = 8'h27;
			end
			EXTERNAL_IRQ_FLAGS: begin
				w1c_mask = 8'hf1;
			end
			COMPARATOR_CONTROL_FLAGS: begin
				w1c_mask = 8'h10;
			end
			default: begin
				w1c_mask = 8'h00;
			end
		endcase
	endfunction

	// Reset causes are sticky but written like ordinary bits
	function automatic logic [7:0] set_mask(input logic [5:0] a);
		set_mask = w1c_mask(a) | ((a == RESET_CAUSE_FLAGS) ? 8'h1f : 8'h00);
	endfunction

	function automatic logic [7:0] ro_mask(input logic [5:0] a);
		case (a)
			PINS_A_INPUT, PINS_B_INPUT, PINS_C_INPUT,
			PINS_D_INPUT, PINS_E_INPUT, PINS_F_INPUT: begin
				ro_mask = 8'hff;
			end
			PINS_G_INPUT: begin
				ro_mask = 8'h3f;
			end
			SERIAL_PORT_FLAGS: begin
				ro_mask = 8'hc0;
			end
			COMPARATOR_CONTROL_FLAGS: begin
				ro_mask = 8'h20;
			end
			SELF_PROGRAM_CONTROL: begin
				ro_mask = 8'h40;
			end
			default: begin
				ro_mask = 8'h00;
			end
		endcase
	endfunction

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	logic                          busy_r;
	logic                          ack_r;
	logic                          skip_r;
	logic                          refused_r;
	logic [7:0]                    rdata_r;
	logic                          ext_req_r;
	logic                          ext_write_r;
	logic [7:0]                    ext_addr_r;
	logic [7:0]                    ext_wdata_r;
	logic [IO_LOCS-1:0]            written_r;
	logic [IO_LOCS-1:0][7:0]       cell_read;
	logic [IO_LOCS-1:0][7:0]       live;
	logic [IO_LOCS-1:0]            implemented;
	logic [PIN_PORTS-1:0][7:0]     pins_sync;

	wire logic is_io    = (i_op == IO_IN_INSTR) || (i_op == IO_OUT_INSTR);
	wire logic is_set   = (i_op == SET_SINGLE_BIT_INSTR);
	wire logic is_bit   = is_set || (i_op == CLEAR_SINGLE_BIT_INSTR);
	wire logic is_clr_t = (i_op == SKIP_IF_BIT_CLEAR_INSTR);
	wire logic is_test  = is_clr_t || (i_op == SKIP_IF_BIT_SET_INSTR);
	wire logic is_data  = (i_op == DATA_LOAD_INSTR) || (i_op == DATA_STORE_INSTR);
	wire logic is_wr_op = (i_op == IO_OUT_INSTR) || (i_op == DATA_STORE_INSTR);

	// A new request is ignored while an extended access is in flight
	wire logic take     = i_req && !busy_r;
	wire logic io_ok    = is_io && (i_addr <= IO_LAST);
	wire logic bit_ok   = (is_bit || is_test) && (i_addr <= BIT_LAST);
	wire logic data_io  = is_data && (i_addr >= DATA_IO_BASE) && (i_addr <= DATA_IO_LAST);
	wire logic data_ext = is_data && (i_addr >= DATA_EXT_BASE);
	wire logic hit      = io_ok || bit_ok || data_io;

	wire logic [7:0] data_off = i_addr - DATA_IO_BASE;
	wire logic [5:0] io_loc   = data_io ? data_off[5:0] : i_addr[5:0];

	wire logic       wr_full  = take && (io_ok || data_io) && is_wr_op;
	wire logic       wr_bit   = take && bit_ok && is_bit;
	wire logic [7:0] bit_lane = 8'h01 << i_bit_sel;
	wire logic [7:0] rd_val   = cell_read[io_loc];
	wire logic       test_bit = rd_val[i_bit_sel];

	// ------------------------------------------------------------
	// Write broadcast to the cells
	// ------------------------------------------------------------
	write_bus_if wb ();

	// Bit operations write one lane, so neighbouring flags stay put
	assign wb.wr_en = wr_full || wr_bit;
	assign wb.loc   = io_loc;
	assign wb.mask  = wr_bit ? bit_lane : 8'hff;
	assign wb.data  = wr_bit ? {8{is_set}} : i_wdata;

	// ------------------------------------------------------------
	// Register cells and pin inputs
	// ------------------------------------------------------------
	for (genvar p = 0; p < PIN_PORTS; p++) begin : g_pin
		pin_sync #(
			.WIDTH (8)
		) u_sync (
			.i_clock (i_clock),
			.i_rst   (i_rst),
			.i_async (i_port_pins[p]),
			.o_sync  (pins_sync[p])
		);
	end

	for (genvar g = 0; g < IO_LOCS; g++) begin : g_loc
		if ((g % PIN_STRIDE == 0) && (g <= int'(PINS_G_INPUT))) begin : g_live_pin
			assign live[g] = pins_sync[g / PIN_STRIDE];
		end else begin : g_live_per
			assign live[g] = i_live_status[g];
		end

		assign implemented[g] = |(rw_mask(6'(g)) | w1c_mask(6'(g)) | ro_mask(6'(g)));

		reg_cell #(
			.LOC (6'(g)),
			.RW  (rw_mask(6'(g))),
			.W1C (w1c_mask(6'(g))),
			.SET (set_mask(6'(g))),
			.RO  (ro_mask(6'(g)))
		) u_cell (
			.i_clock  (i_clock),
			.i_rst    (i_rst),
			.wb       (wb.sink),
			.i_set    (i_flag_set[g]),
			.i_live   (live[g]),
			.o_stored (o_io_image[g]),
			.o_read   (cell_read[g])
		);
	end

	// ------------------------------------------------------------
	// Answer to the core
	// ------------------------------------------------------------
	wire logic       local_rd  = take && hit && !is_wr_op && !is_bit;
	wire logic       ack_nxt   = (take && !data_ext) || ext_req_r;
	wire logic       refuse    = take && !hit && !data_ext;
	wire logic       skip_nxt  = take && bit_ok && is_test && (test_bit ^ is_clr_t);
	// Unassigned locations hold nothing, so they read zero
	wire logic [7:0] local_val = local_rd ? rd_val : 8'h00;
	wire logic [7:0] ext_val   = ext_write_r ? 8'h00 : i_ext_rdata;
	wire logic [7:0] rdata_nxt = ext_req_r ? ext_val : local_val;
	wire logic [IO_LOCS-1:0] written_nxt = wb.wr_en ? (64'h1 << io_loc) : '0;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ack_r     <= 1'b0;
			refused_r <= 1'b0;
			skip_r    <= 1'b0;
			rdata_r   <= 8'h00;
			written_r <= '0;
		end else begin
			ack_r     <= ack_nxt;
			refused_r <= refuse;
			skip_r    <= skip_nxt;
			rdata_r   <= rdata_nxt;
			written_r <= written_nxt;
		end
	end

	// ------------------------------------------------------------
	// Extended data space, loads and stores only
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ext_req_r   <= 1'b0;
			ext_write_r <= 1'b0;
			ext_addr_r  <= 8'h00;
			ext_wdata_r <= 8'h00;
		end else begin
			ext_req_r   <= take && data_ext;
			ext_write_r <= take && data_ext && is_wr_op;
			ext_addr_r  <= data_ext ? i_addr : ext_addr_r;
			ext_wdata_r <= data_ext ? i_wdata : ext_wdata_r;
		end
	end

	assign busy_r       = ext_req_r;
	assign o_ack        = ack_r;
	assign o_refused    = refused_r;
	assign o_skip       = skip_r;
	assign o_rdata      = rdata_r;
	assign o_io_written = written_r;
	assign o_ext_req    = ext_req_r;
	assign o_ext_write  = ext_write_r;
	assign o_ext_addr   = ext_addr_r;
	assign o_ext_wdata  = ext_wdata_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	wire logic [5:0] alias_loc = {i_addr[6], i_addr[4:0]};
	wire logic [7:0] alias_rd  = cell_read[alias_loc];
	wire logic [7:0] cur_img   = o_io_image[io_loc];
	wire logic [7:0] set_here  = i_flag_set[io_loc];
	wire logic [7:0] lane_now  = wb.mask;
	wire logic       t0_flag   = o_io_image[TIMER0_FLAGS][0];
	wire logic       t0_set    = i_flag_set[TIMER0_FLAGS][0];
	wire logic       wd0       = i_wdata[0];
	wire logic       t0_write  = wr_full && (io_loc == TIMER0_FLAGS);
	wire logic       unassigned = !implemented[io_loc];

	sequence s_ext_take;
		take && data_ext;
	endsequence

	sequence s_ext_answer;
		o_ext_req ##1 (o_ack && !o_refused);
	endsequence

	sequence s_refused_answer;
		!wb.wr_en ##1 (o_ack && o_refused && !o_skip);
	endsequence

	AST_BIT_OP_RANGE: assert property (
		(take && (is_bit || is_test) && (i_addr > BIT_LAST)) |-> s_refused_answer
	) else $error("bit operation above 0x1f was not refused");

	AST_SKIP_VALUE: assert property (
		(take && bit_ok && is_test) |=> o_ack && (o_skip == ($past(test_bit) ^ $past(is_clr_t)))
	) else $error("skip answer does not match the tested bit");

	AST_W1C_CLEAR: assert property (
		(t0_write && !t0_set) |=> (t0_flag == ($past(t0_flag) && !$past(wd0)))
	) else $error("write-one-to-clear flag handled wrongly");

	AST_SET_BEATS_CLEAR: assert property (
		(t0_write && wd0 && t0_set) |=> t0_flag
	) else $error("flag event lost in its clearing cycle");

	AST_BIT_OP_ISOLATION: assert property (
		wr_bit |=> (((o_io_image[$past(io_loc)] ^ $past(cur_img))
			& ~$past(lane_now) & ~$past(set_here)) == 8'h00)
	) else $error("single-bit operation disturbed another bit");

	AST_IO_WINDOW: assert property (
		(take && is_io) |=> o_ack && (o_refused == ($past(i_addr) > IO_LAST))
	) else $error("in/out address window misdecoded");

	AST_DATA_OFFSET: assert property (
		(take && data_io && !is_wr_op) |=> o_ack && (o_rdata == $past(alias_rd))
	) else $error("data-space alias does not read the register at minus 0x20");

	AST_EXT_ONLY_DATA: assert property (
		s_ext_take |=> s_ext_answer
	) else $error("extended data access not passed on and answered");

	AST_EXT_SOURCE: assert property (
		o_ext_req |-> $past(is_data) && ($past(i_addr) >= DATA_EXT_BASE)
	) else $error("extended space reached by a non data-space operation");

	AST_UNASSIGNED_ZERO: assert property (
		(take && unassigned && !data_ext) |=> o_ack && (o_rdata == 8'h00)
	) else $error("unassigned location did not read zero");

endmodule // io_space_register_decoder

// ---- bench/ext_space_model.sv ----
module ext_space_model (
	// Clock
	input  wire logic       i_clock,
	// Extended space access
	input  wire logic       i_ext_req,
	input  wire logic       i_ext_write,
	input  wire logic [7:0] i_ext_addr,
	input  wire logic [7:0] i_ext_wdata,
	output logic      [7:0] o_ext_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [0:255];
	logic [7:0] last_r;

	// Outside an access the bus is released, so show the inverse of the last value
	assign o_ext_rdata = i_ext_req ? mem[i_ext_addr] : ~last_r;

	always_ff @(posedge i_clock) begin
		if (i_ext_req) begin
			last_r <= mem[i_ext_addr];
		end
		if (i_ext_req && i_ext_write) begin
			mem[i_ext_addr] <= i_ext_wdata;
		end
	end

endmodule // ext_space_model

// ---- bench/io_space_register_decoder_tb_top.sv ----
module io_space_register_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import io_space_pkg::*;

`define CHK(name, exp, got) \
	check_count++; \
	if ((got) !== (exp)) begin \
		$display("unexpected %s expected %h seen %h", name, exp, got); \
		n_mismatch++; \
	end

	logic                          i_clock;
	logic                          i_rst;
	logic                          i_req;
	op_t                           i_op;
	logic [7:0]                    i_addr;
	logic [7:0]                    i_wdata;
	logic [2:0]                    i_bit_sel;
	logic                          o_ack;
	logic [7:0]                    o_rdata;
	logic                          o_skip;
	logic                          o_refused;
	logic [PIN_PORTS-1:0][7:0]     i_port_pins;
	logic [IO_LOCS-1:0][7:0]       i_flag_set;
	logic [IO_LOCS-1:0][7:0]       i_live_status;
	logic [IO_LOCS-1:0][7:0]       o_io_image;
	logic [IO_LOCS-1:0]            o_io_written;
	logic [IO_LOCS-1:0]            wr;
	logic                          o_ext_req;
	logic                          o_ext_write;
	logic [7:0]                    o_ext_addr;
	logic [7:0]                    o_ext_wdata;
	logic [7:0]                    i_ext_rdata;
	logic [7:0]                    rd;
	logic                          sk;
	logic                          rf;
	int                            n_mismatch;
	int                            check_count;

	io_space_register_decoder u_dut (
		.i_clock       (i_clock),
		.i_rst         (i_rst),
		.i_req         (i_req),
		.i_op          (i_op),
		.i_addr        (i_addr),
		.i_wdata       (i_wdata),
		.i_bit_sel     (i_bit_sel),
		.o_ack         (o_ack),
		.o_rdata       (o_rdata),
		.o_skip        (o_skip),
		.o_refused     (o_refused),
		.i_port_pins   (i_port_pins),
		.i_live_status (i_live_status),
		.i_flag_set    (i_flag_set),
		.o_io_image    (o_io_image),
		.o_io_written  (o_io_written),
		.o_ext_req     (o_ext_req),
		.o_ext_write   (o_ext_write),
		.o_ext_addr    (o_ext_addr),
		.o_ext_wdata   (o_ext_wdata),
		.i_ext_rdata   (i_ext_rdata)
	);

	ext_space_model u_ext (
		.i_clock     (i_clock),
		.i_ext_req   (o_ext_req),
		.i_ext_write (o_ext_write),
		.i_ext_addr  (o_ext_addr),
		.i_ext_wdata (o_ext_wdata),
		.o_ext_rdata (i_ext_rdata)
	);

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	// ------------------------------------------------------------
	// Access and closing tasks
	// ------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One request, then a bounded wait for the answer, one cycle later or two for the extended space
	task automatic acc(input op_t op, input logic [7:0] a, input logic [7:0] d,
			input logic [2:0] b);
		int n;
		@(posedge i_clock);
		i_req     <= 1'b1;
		i_op      <= op;
		i_addr    <= a;
		i_wdata   <= d;
		i_bit_sel <= b;
		@(posedge i_clock);
		i_req <= 1'b0;
		#1;
		n = 0;
		while (o_ack !== 1'b1 && n < 4) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		rd = o_rdata;
		sk = o_skip;
		rf = o_refused;
		wr = o_io_written;
		// A lost answer ends the run here rather than hanging the sequence
		if (o_ack !== 1'b1) begin
			$display("unexpected ack timeout at address %h", a);
			n_mismatch++;
			test_done();
		end
	endtask

	task automatic flag_pulse(input logic [5:0] loc, input logic [7:0] v);
		@(posedge i_clock);
		i_flag_set[loc] <= v;
		@(posedge i_clock);
		i_flag_set[loc] <= 8'h00;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		check_count = 0;
		i_rst = 1'b1;
		i_req = 1'b0;
		i_op = IO_IN_INSTR;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_bit_sel = 3'h0;
		i_port_pins = '0;
		i_flag_set = '0;
		i_live_status = '0;
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		i_port_pins[0] <= 8'h08;
		i_live_status[SERIAL_PORT_FLAGS] <= 8'hff;
		// Full-width writes and reads, both address views
		acc(IO_OUT_INSTR, 8'h1e, 8'h5a, 3'h0);
		`CHK("written scratch", 64'h0000_0000_4000_0000, wr)
		acc(IO_IN_INSTR, 8'h1e, 8'h00, 3'h0);
		`CHK("in scratch", 8'h5a, rd)
		acc(DATA_LOAD_INSTR, 8'h3e, 8'h00, 3'h0);
		`CHK("load scratch", 8'h5a, rd)
		acc(DATA_STORE_INSTR, 8'h21, 8'hc3, 3'h0);
		`CHK("image dir a", 8'hc3, o_io_image[DIRECTION_A])
		`CHK("written dir a", 64'h2, wr)
		acc(IO_IN_INSTR, 8'h40, 8'h00, 3'h0);
		`CHK("in past 0x3f refused", 1'b1, rf)
		acc(IO_IN_INSTR, 8'h3f, 8'h00, 3'h0);
		`CHK("in 0x3f taken", 1'b0, rf)
		// Single-bit operations
		acc(SET_SINGLE_BIT_INSTR, 8'h1e, 8'h00, 3'h0);
		acc(CLEAR_SINGLE_BIT_INSTR, 8'h1e, 8'h00, 3'h1);
		acc(IO_IN_INSTR, 8'h1e, 8'h00, 3'h0);
		`CHK("bit ops scratch", 8'h59, rd)
		acc(IO_OUT_INSTR, 8'h20, 8'h00, 3'h0);
		acc(SET_SINGLE_BIT_INSTR, 8'h20, 8'h00, 3'h2);
		`CHK("bit op at 0x20 refused", 1'b1, rf)
		`CHK("no write from refused bit op", 64'h0, wr)
		acc(IO_IN_INSTR, 8'h20, 8'h00, 3'h0);
		`CHK("0x20 unchanged", 8'h00, rd)
		// Write-one-to-clear flags
		flag_pulse(TIMER0_FLAGS, 8'h03);
		acc(IO_OUT_INSTR, 8'h15, 8'h01, 3'h0);
		acc(IO_IN_INSTR, 8'h15, 8'h00, 3'h0);
		`CHK("w1c full write", 8'h02, rd)
		flag_pulse(TIMER0_FLAGS, 8'h03);
		acc(SET_SINGLE_BIT_INSTR, 8'h15, 8'h00, 3'h1);
		acc(IO_IN_INSTR, 8'h15, 8'h00, 3'h0);
		`CHK("bit set keeps other flag", 8'h01, rd)
		acc(CLEAR_SINGLE_BIT_INSTR, 8'h15, 8'h00, 3'h0);
		acc(IO_IN_INSTR, 8'h15, 8'h00, 3'h0);
		`CHK("bit clear on flag", 8'h01, rd)
		// A flag event in the clearing cycle must survive
		fork
			flag_pulse(TIMER0_FLAGS, 8'h01);
			acc(IO_OUT_INSTR, 8'h15, 8'h01, 3'h0);
		join
		acc(IO_IN_INSTR, 8'h15, 8'h00, 3'h0);
		`CHK("event beats clear", 8'h01, rd)
		// Bit tests on the synchronised pins
		acc(SKIP_IF_BIT_SET_INSTR, 8'h00, 8'h00, 3'h3);
		`CHK("skip if set", 1'b1, sk)
		acc(SKIP_IF_BIT_CLEAR_INSTR, 8'h00, 8'h00, 3'h3);
		`CHK("skip if clear", 1'b0, sk)
		acc(SKIP_IF_BIT_CLEAR_INSTR, 8'h00, 8'h00, 3'h2);
		`CHK("skip if clear low", 1'b1, sk)
		acc(SKIP_IF_BIT_SET_INSTR, 8'h20, 8'h00, 3'h0);
		`CHK("skip past 0x1f", 2'b10, {rf, sk})
		// Extended space through data ops only
		acc(DATA_STORE_INSTR, 8'h80, 8'h11, 3'h0);
		acc(DATA_STORE_INSTR, 8'hff, 8'h7e, 3'h0);
		acc(DATA_LOAD_INSTR, 8'h80, 8'h00, 3'h0);
		`CHK("ext load", 8'h11, rd)
		acc(DATA_LOAD_INSTR, 8'hff, 8'h00, 3'h0);
		`CHK("ext load top", 8'h7e, rd)
		acc(IO_IN_INSTR, 8'h80, 8'h00, 3'h0);
		`CHK("in to ext refused", 1'b1, rf)
		acc(DATA_LOAD_INSTR, 8'h10, 8'h00, 3'h0);
		`CHK("load below 0x20 refused", 1'b1, rf)
		// Unassigned places and unused bits, read as zero
		acc(IO_IN_INSTR, 8'h18, 8'h00, 3'h0);
		`CHK("unassigned reads zero", 8'h00, rd)
		acc(IO_OUT_INSTR, 8'h13, 8'hff, 3'h0);
		acc(IO_IN_INSTR, 8'h13, 8'h00, 3'h0);
		`CHK("unused bits dir g", 8'h1f, rd)
		// Live status shows only in read-only bits; unused bits written as zero
		acc(IO_OUT_INSTR, 8'h2d, 8'h01, 3'h0);
		acc(IO_IN_INSTR, 8'h2d, 8'h00, 3'h0);
		`CHK("serial flags live bits", 8'hc1, rd)
		acc(IO_IN_INSTR, 8'h00, 8'h00, 3'h0);
		`CHK("pins a", 8'h08, rd)
		test_done();
	end

endmodule // io_space_register_decoder_tb_top
